// *** hw/nvm_pkg.sv ***
package nvm_pkg;
	// ==========================================
	// Register map
	localparam logic [15:0] EPROM_CTRL_ADDR = 16'h002B;
	localparam logic [15:0] EEPROM_CTRL_ADDR = 16'h003B;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// eprom_program_control fields
	localparam int MBE_BIT = 7;
	localparam int EPROM_LATCH_BIT = 5;
	localparam int EXTRA_COLUMN_SELECT_BIT = 4;
	localparam int EXTRA_ROW_SELECT_BIT = 3;
	localparam int EPROM_VOLTAGE_ON_BIT = 0;
	localparam logic [7:0] EPROM_CTRL_RMASK = 8'hB9;
	// eeprom_program_control fields
	localparam int ODD_BIT = 7;
	localparam int EVEN_BIT = 6;
	localparam int BYTE_BIT = 4;
	localparam int ROW_BIT = 3;
	localparam int ERASE_BIT = 2;
	localparam int EEPROM_LATCH_BIT = 1;
	localparam int EEPROM_VOLTAGE_ON_BIT = 0;
	localparam logic [7:0] EEPROM_CTRL_RMASK = 8'hDF;
	// ==========================================
	// Arrays
	localparam logic [15:0] EPROM_BASE = 16'h4000;
	localparam logic [15:0] MBE_IGNORE_MASK = 16'hC090;
	localparam logic [4:0] EXTRA_COLUMN_SELECT_LOW_ONES = 5'h1F;
	localparam logic [3:0] EEPROM_PAGE_RESET = 4'h0;
	localparam logic [11:0] EEPROM_PAGE_OFFSET = 12'hE00;
	localparam logic [8:0] BLK1_START = 9'h020;
	localparam logic [8:0] BLK2_START = 9'h060;
	localparam logic [8:0] BLK3_START = 9'h0E0;
	localparam int BULKP_BIT = 7;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	// ==========================================
	// Types
	typedef enum logic [1:0] {
		SCOPE_BULK = 2'b00,
		SCOPE_ROW = 2'b01,
		SCOPE_BYTE = 2'b10,
		SCOPE_PROGRAM = 2'b11
	} scope_type;
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] ignore_mask;
		logic [7:0] data;
	} eprom_req_type;
	typedef struct packed {
		logic [8:0] addr;
		logic [7:0] data;
		scope_type scope;
		logic all_rows;
	} eeprom_req_type;
endpackage : nvm_pkg

// *** hw/eprom_eeprom_program_control.sv ***
`timescale 1ns/1ps
// Operation
// RULE1: Multi-byte mode ignores address bits 4, 7, 14, 15; sixteen bytes programmed.
// RULE2: Multi-byte enable accessible only in special modes, else reads zero.
// RULE3: EPROM control bits 6, 2, 1 always read zero.
// RULE4: EPROM latch captures write address and data; EPROM reads blocked meanwhile.
// RULE5: Extra column select disables user array; column at bit 7, low bits ones.
// RULE6: Extra row select disables user array; six rows, address bits 11-7 zero.
// RULE7: EPROM voltage bit writable only with latch set; zero when latch clear.
// RULE8: Software programs EPROM with 0x20, store, 0x21, wait, clear.
// RULE9: EEPROM sits at default page after reset, relocatable to any 4K page; the page comes from eeprom_map_register, which is never reset here.
// RULE10: Erased EEPROM bytes read back as 0xFF.
// RULE11: EEPROM writes blocked while voltage on; other-location writes rejected mid-operation.
// RULE12: Odd and even both set program all rows of half the EEPROM.
// RULE13: EEPROM control bit 5 always reads zero.
// RULE14: Erase scope: both clear bulk, row alone row, byte set byte.
// RULE15: Erase bit selects erase when set, read or program when clear.
// RULE16: EEPROM latch captures address and data; clear means ROM-like reads.
// RULE17: EEPROM voltage bit writable only with latch set; zero when latch clear.
// RULE18: Row and byte scope bits ignored during EEPROM programming.
// RULE19: Software erases with scope bits, dummy write, voltage, wait, clear.
// RULE20: Software programs EEPROM with 0x02, store, 0x03, wait, clear.
// RULE21: Software erases a location before programming it.
// RULE22: Software selects internal oscillator at bus clock 1MHz or lower.
// RULE23: Protected EEPROM blocks of 32, 64, 128, 288 bytes refuse program and erase.
// RULE24: Voltage stays on while its bit is set; no hardware timeout.
module eprom_eeprom_program_control (
	input wire logic mclk, // Bus clock
	input wire logic srst, // Synchronous reset, high
	input wire logic special_mode, // Special bootstrap or test mode
	input wire logic [15:0] bus_addr, // CPU address
	input wire logic [7:0] bus_wdata, // CPU write data
	input wire logic bus_we, // CPU write strobe
	input wire logic bus_re, // CPU read strobe
	output logic [7:0] bus_rdata, // Register read data
	output logic bus_rvalid, // Read data valid
	input wire logic [7:0] block_protect_register, // Block protect bits
	input wire logic [3:0] eeprom_map_register, // EEPROM 4K page
	output nvm_pkg::eprom_req_type eprom_req, // Latched EPROM request
	output logic eprom_req_valid, // EPROM request captured
	output logic eprom_read_en, // EPROM may be read
	output logic user_array_disable, // EPROM user array off
	output logic extra_column_hit, // Extra column addressed
	output logic extra_row_hit, // Extra row addressed
	output logic external_program_supply, // EPROM supply switch
	output nvm_pkg::eeprom_req_type eeprom_req, // Latched EEPROM request
	output logic eeprom_req_valid, // EEPROM request captured
	output logic eeprom_read_en, // EEPROM read as ROM
	output logic eeprom_select, // Address inside EEPROM
	output logic eeprom_pump_on, // Charge pump to array
	output logic write_refused // Rejected EEPROM write
);
	// ==========================================
	// Helpers
	function automatic logic [1:0] block_of(input logic [8:0] off);
		if (off < nvm_pkg::BLK1_START) begin
			block_of = 2'd0;
		end else if (off < nvm_pkg::BLK2_START) begin
			block_of = 2'd1;
		end else if (off < nvm_pkg::BLK3_START) begin
			block_of = 2'd2;
		end else begin
			block_of = 2'd3;
		end
	endfunction : block_of

	// Scope is decoded for the register and for its next value alike
	function automatic nvm_pkg::scope_type scope_of(input logic [7:0] ctrl);
		if (!ctrl[nvm_pkg::ERASE_BIT]) begin
			scope_of = nvm_pkg::SCOPE_PROGRAM; // [RULE18]
		end else if (ctrl[nvm_pkg::BYTE_BIT]) begin
			scope_of = nvm_pkg::SCOPE_BYTE; // [RULE14]
		end else if (ctrl[nvm_pkg::ROW_BIT]) begin
			scope_of = nvm_pkg::SCOPE_ROW; // [RULE14]
		end else begin
			scope_of = nvm_pkg::SCOPE_BULK; // [RULE14]
		end
	endfunction : scope_of

	logic mbe_q;
	logic eprom_latch_q;
	logic extra_column_select_q;
	logic extra_row_select_q;
	logic eprom_voltage_on_q;
	logic [7:0] ee_ctrl_q;
	logic eprom_latch_d;
	logic eprom_voltage_on_d;
	logic [7:0] ee_ctrl_d;
	logic ep_ctrl_wr;
	logic ee_ctrl_wr;
	logic ep_hit;
	logic ee_all_rows;
	logic ee_erase;
	logic ee_latch;
	logic ee_pgm;
	logic [8:0] ee_off;
	logic ee_protected;
	nvm_pkg::scope_type scope;
	logic [7:0] ep_view;
	logic [7:0] ee_view;
	logic ee_refuse;

	assign ep_ctrl_wr = bus_we && (bus_addr == nvm_pkg::EPROM_CTRL_ADDR);
	assign ee_ctrl_wr = bus_we && (bus_addr == nvm_pkg::EEPROM_CTRL_ADDR);

	// ==========================================
	// EPROM control register
	always_comb begin
		eprom_latch_d = eprom_latch_q;
		eprom_voltage_on_d = eprom_voltage_on_q;
		if (ep_ctrl_wr) begin
			eprom_latch_d = bus_wdata[nvm_pkg::EPROM_LATCH_BIT]; // [RULE4]
			if (eprom_latch_q) begin
				eprom_voltage_on_d = bus_wdata[nvm_pkg::EPROM_VOLTAGE_ON_BIT]; // [RULE7]
			end
		end
		if (!eprom_latch_d) begin
			eprom_voltage_on_d = 1'b0; // [RULE7]
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			eprom_latch_q <= 1'b0;
			eprom_voltage_on_q <= 1'b0;
		end else begin
			eprom_latch_q <= eprom_latch_d;
			eprom_voltage_on_q <= eprom_voltage_on_d;
		end
	end

	// Test bits only move in special modes and are masked again on use,
	// so leaving special mode cannot leave a stale test selection active
	always_ff @(posedge mclk) begin
		if (srst) begin
			mbe_q <= 1'b0;
			extra_column_select_q <= 1'b0;
			extra_row_select_q <= 1'b0;
		end else if (ep_ctrl_wr && special_mode) begin
			mbe_q <= bus_wdata[nvm_pkg::MBE_BIT]; // [RULE2]
			extra_column_select_q <= bus_wdata[nvm_pkg::EXTRA_COLUMN_SELECT_BIT]; // [RULE5]
			extra_row_select_q <= bus_wdata[nvm_pkg::EXTRA_ROW_SELECT_BIT]; // [RULE6]
		end
	end

	always_comb begin
		ep_view = nvm_pkg::CTRL_RESET;
		ep_view[nvm_pkg::MBE_BIT] = mbe_q && special_mode; // [RULE2]
		ep_view[nvm_pkg::EPROM_LATCH_BIT] = eprom_latch_q;
		ep_view[nvm_pkg::EXTRA_COLUMN_SELECT_BIT] = extra_column_select_q && special_mode; // [RULE5]
		ep_view[nvm_pkg::EXTRA_ROW_SELECT_BIT] = extra_row_select_q && special_mode; // [RULE6]
		ep_view[nvm_pkg::EPROM_VOLTAGE_ON_BIT] = eprom_voltage_on_q;
		ep_view = ep_view & nvm_pkg::EPROM_CTRL_RMASK; // [RULE3]
	end

	// ==========================================
	// EPROM latches and array controls
	assign ep_hit = bus_addr >= nvm_pkg::EPROM_BASE;

	always_ff @(posedge mclk) begin
		if (srst) begin
			eprom_req <= '0;
			eprom_req_valid <= 1'b0;
		end else if (!eprom_latch_q) begin
			eprom_req_valid <= 1'b0;
		end else if (bus_we && ep_hit && !eprom_voltage_on_q) begin
			eprom_req.addr <= bus_addr; // [RULE4]
			eprom_req.data <= bus_wdata; // [RULE4]
			eprom_req.ignore_mask <= (mbe_q && special_mode) ?
				nvm_pkg::MBE_IGNORE_MASK : 16'h0000; // [RULE1]
			eprom_req_valid <= 1'b1;
		end
	end

	assign eprom_read_en = !eprom_latch_q; // [RULE4]
	assign user_array_disable = special_mode && (extra_column_select_q || extra_row_select_q); // [RULE5] [RULE6]
	assign extra_column_hit = special_mode && extra_column_select_q &&
		(bus_addr[4:0] == nvm_pkg::EXTRA_COLUMN_SELECT_LOW_ONES); // [RULE5]
	assign extra_row_hit = special_mode && extra_row_select_q && (bus_addr[11:7] == 5'h00); // [RULE6]
	// Held for as long as software leaves the bit set
	assign external_program_supply = eprom_voltage_on_q && eprom_latch_q; // [RULE24] [RULE7]

	// ==========================================
	// EEPROM control register
	always_comb begin
		ee_ctrl_d = ee_ctrl_q;
		if (ee_ctrl_wr) begin
			ee_ctrl_d = bus_wdata & nvm_pkg::EEPROM_CTRL_RMASK; // [RULE13]
			ee_ctrl_d[nvm_pkg::EEPROM_VOLTAGE_ON_BIT] = ee_ctrl_q[nvm_pkg::EEPROM_LATCH_BIT] ?
				bus_wdata[nvm_pkg::EEPROM_VOLTAGE_ON_BIT] : ee_ctrl_q[nvm_pkg::EEPROM_VOLTAGE_ON_BIT]; // [RULE17]
		end
		if (!ee_ctrl_d[nvm_pkg::EEPROM_LATCH_BIT]) begin
			ee_ctrl_d[nvm_pkg::EEPROM_VOLTAGE_ON_BIT] = 1'b0; // [RULE17]
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			ee_ctrl_q <= nvm_pkg::CTRL_RESET;
		end else begin
			ee_ctrl_q <= ee_ctrl_d;
		end
	end

	assign ee_erase = ee_ctrl_q[nvm_pkg::ERASE_BIT]; // [RULE15]
	assign ee_latch = ee_ctrl_q[nvm_pkg::EEPROM_LATCH_BIT];
	assign ee_pgm = ee_ctrl_q[nvm_pkg::EEPROM_VOLTAGE_ON_BIT];
	assign ee_view = ee_ctrl_q & nvm_pkg::EEPROM_CTRL_RMASK; // [RULE13]
	// Both test row selects together raise the all_rows flag of the request
	assign ee_all_rows = ee_ctrl_d[nvm_pkg::ODD_BIT] &&
		ee_ctrl_d[nvm_pkg::EVEN_BIT]; // [RULE12]

	always_comb begin
		scope = scope_of(ee_ctrl_q); // [RULE14] [RULE18]
	end

	// ==========================================
	// EEPROM decode, protection and latches
	// The page follows the map register live; nothing in this module resets it to the default page
	assign eeprom_select = (bus_addr[15:12] == eeprom_map_register) &&
		(bus_addr[11:9] == nvm_pkg::EEPROM_PAGE_OFFSET[11:9]); // [RULE9]
	assign ee_off = bus_addr[8:0];

	// Bulk and row erases touch more than one byte, so they also honour
	// the bulk protect bit and, for bulk, every block bit
	always_comb begin
		ee_protected = block_protect_register[block_of(ee_off)]; // [RULE23]
		if (scope == nvm_pkg::SCOPE_BULK) begin
			ee_protected = block_protect_register[nvm_pkg::BULKP_BIT] ||
				(block_protect_register[3:0] != 4'h0); // [RULE23]
		end else if (scope == nvm_pkg::SCOPE_ROW) begin
			ee_protected = ee_protected || block_protect_register[nvm_pkg::BULKP_BIT]; // [RULE23]
		end
	end

	// A write is refused while the pump bit is set, into a protected block,
	// or to a new location once one is already latched
	always_comb begin
		ee_refuse = 1'b0;
		if (bus_we && eeprom_select && ee_latch) begin
			if (ee_pgm) begin
				ee_refuse = 1'b1; // [RULE11]
			end else if (ee_protected) begin
				ee_refuse = 1'b1; // [RULE23]
			end else if (eeprom_req_valid && (ee_off != eeprom_req.addr)) begin
				ee_refuse = 1'b1; // [RULE11]
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			eeprom_req <= '0;
			eeprom_req_valid <= 1'b0;
		end else begin
			// Scope and row mode follow the control register so that software
			// may change them between the store and the pump command
			eeprom_req.scope <= scope_of(ee_ctrl_d); // [RULE14] [RULE18]
			eeprom_req.all_rows <= ee_all_rows; // [RULE12]
			if (!ee_latch) begin
				eeprom_req_valid <= 1'b0;
			end else if (bus_we && eeprom_select && !ee_refuse) begin
				eeprom_req.addr <= ee_off; // [RULE16]
				eeprom_req.data <= ee_erase ? nvm_pkg::ERASED_BYTE : bus_wdata; // [RULE10]
				eeprom_req_valid <= 1'b1;
			end
		end
	end

	assign eeprom_read_en = eeprom_select && !ee_latch; // [RULE16]
	// Held for as long as software leaves the bit set
	assign eeprom_pump_on = ee_pgm && ee_latch && eeprom_req_valid; // [RULE24] [RULE17]

	always_ff @(posedge mclk) begin
		if (srst) begin
			write_refused <= 1'b0;
		end else begin
			write_refused <= ee_refuse;
		end
	end

	// ==========================================
	// Register read port
	always_ff @(posedge mclk) begin
		if (srst) begin
			bus_rdata <= 8'h00;
			bus_rvalid <= 1'b0;
		end else begin
			bus_rvalid <= bus_re;
			if (!bus_re) begin
				bus_rdata <= 8'h00;
			end else if (bus_addr == nvm_pkg::EPROM_CTRL_ADDR) begin
				bus_rdata <= ep_view;
			end else if (bus_addr == nvm_pkg::EEPROM_CTRL_ADDR) begin
				bus_rdata <= ee_view;
			end else begin
				bus_rdata <= 8'h00;
			end
		end
	end

endmodule : eprom_eeprom_program_control

// *** verif/nvm_ctrl_chk.sv ***
`timescale 1ns/1ps
module nvm_ctrl_chk (
	input wire logic mclk, // Bus clock
	input wire logic srst, // Sync reset
	input wire logic special_mode, // Test modes
	input wire logic [15:0] bus_addr, // CPU address
	input wire logic bus_we, // Write strobe
	input wire logic bus_rvalid, // Read valid
	input wire logic [7:0] bus_rdata, // Read data
	input wire logic eprom_read_en, // EPROM readable
	input wire logic eprom_req_valid, // EPROM capture
	input wire logic external_program_supply, // EPROM supply
	input wire logic eeprom_req_valid, // EEPROM capture
	input wire logic eeprom_read_en, // EEPROM as ROM
	input wire logic eeprom_select, // EEPROM hit
	input wire logic eeprom_pump_on, // Charge pump
	input wire logic write_refused // Refused write
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	// ==========================================
	// Voltage and latch
	a_supply_latch: assert property (external_program_supply |-> !eprom_read_en)
		else $error("supply on without latch");
	a_eprom_locked: assert property (eprom_read_en |=> !eprom_req_valid)
		else $error("eprom capture kept while readable");
	a_pump_latch: assert property (eeprom_pump_on |-> eeprom_req_valid && !eeprom_read_en)
		else $error("pump on without latch");
	a_supply_holds: assert property (external_program_supply && !(bus_we &&
		bus_addr == nvm_pkg::EPROM_CTRL_ADDR) |=> external_program_supply)
		else $error("supply dropped by itself");
	a_pumped_refuse: assert property (bus_we && eeprom_select && eeprom_pump_on
		|=> write_refused && $stable(eeprom_req_valid))
		else $error("write not refused while pumping");
	// ==========================================
	// Read-back of control registers
	a_eprom_zeros: assert property (bus_rvalid && $past(bus_addr) ==
		nvm_pkg::EPROM_CTRL_ADDR |-> (bus_rdata & 8'h46) == 8'h00)
		else $error("eprom control spare bits set");
	a_eeprom_zero: assert property (bus_rvalid && $past(bus_addr) ==
		nvm_pkg::EEPROM_CTRL_ADDR |-> bus_rdata[5] == 1'b0)
		else $error("eeprom control spare bit set");
	a_test_hidden: assert property (bus_rvalid && !$past(special_mode) &&
		$past(bus_addr) == nvm_pkg::EPROM_CTRL_ADDR |-> (bus_rdata & 8'h98) == 8'h00)
		else $error("test bits visible in normal mode");
	c_supply: cover property (external_program_supply);
	c_pump: cover property (eeprom_pump_on);
	c_refused: cover property (write_refused);
endmodule : nvm_ctrl_chk

// *** verif/nvm_array_model.sv ***
`timescale 1ns/1ps
module nvm_array_model (
	input wire logic mclk, // Bus clock
	input wire nvm_pkg::eeprom_req_type eeprom_req, // Latched request
	input wire logic eeprom_pump_on, // Charge pump
	input wire logic [8:0] peek_addr, // Read-back offset
	output logic [7:0] peek_data // Cell contents
);
	logic [7:0] cell_q [512];
	logic pump_q = 1'b0;
	initial begin
		foreach (cell_q[i]) cell_q[i] = 8'hFF;
	end
	assign peek_data = cell_q[peek_addr];
	// Cells change once per pump pulse, however long the voltage stays on
	always @(posedge mclk) begin
		pump_q <= eeprom_pump_on;
		if (eeprom_pump_on && !pump_q) begin
			for (int i = 0; i < 512; i++) begin
				if (eeprom_req.scope == nvm_pkg::SCOPE_PROGRAM) begin
					if (9'(i) == eeprom_req.addr) cell_q[i] <= cell_q[i] & eeprom_req.data;
				end else if (eeprom_req.scope == nvm_pkg::SCOPE_BULK ||
					(eeprom_req.scope == nvm_pkg::SCOPE_ROW && 9'(i) >> 4 == eeprom_req.addr >> 4) ||
					(eeprom_req.scope == nvm_pkg::SCOPE_BYTE && 9'(i) == eeprom_req.addr)) begin
					cell_q[i] <= 8'hFF;
				end
			end
		end
	end
endmodule : nvm_array_model

// *** verif/eprom_eeprom_program_control_tb_top.sv ***
`timescale 1ns/1ps
module eprom_eeprom_program_control_tb_top;
	localparam logic [15:0] ep = nvm_pkg::EPROM_CTRL_ADDR;
	localparam logic [15:0] ee = nvm_pkg::EEPROM_CTRL_ADDR;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic special_mode = 1'b0;
	logic [15:0] bus_addr = 16'h0000;
	logic [7:0] bus_wdata = 8'h00;
	logic bus_we = 1'b0;
	logic bus_re = 1'b0;
	logic [7:0] block_protect_register = 8'h00;
	logic [3:0] eeprom_map_register = 4'h0;
	logic [8:0] peek_addr = 9'h025;
	logic [7:0] bus_rdata, peek_data, rd_q;
	logic bus_rvalid, eprom_req_valid, eprom_read_en, external_program_supply;
	logic eeprom_req_valid, eeprom_pump_on, write_refused;
	logic user_array_disable, extra_column_hit, extra_row_hit, eeprom_read_en, eeprom_select;
	nvm_pkg::eprom_req_type eprom_req;
	nvm_pkg::eeprom_req_type eeprom_req;
	logic [7:0] ctl [4] = '{8'h06, 8'h0E, 8'h16, 8'h1E};
	nvm_pkg::scope_type scp [4] = '{nvm_pkg::SCOPE_BULK, nvm_pkg::SCOPE_ROW,
		nvm_pkg::SCOPE_BYTE, nvm_pkg::SCOPE_BYTE};
	int errors = 0;
	int tests_run = 0;
	eprom_eeprom_program_control uut (.mclk(mclk), .srst(srst), .special_mode(special_mode),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_we(bus_we), .bus_re(bus_re),
		.bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
		.block_protect_register(block_protect_register),
		.eeprom_map_register(eeprom_map_register), .eprom_req(eprom_req),
		.eprom_req_valid(eprom_req_valid), .eprom_read_en(eprom_read_en),
		.user_array_disable(user_array_disable), .extra_column_hit(extra_column_hit),
		.extra_row_hit(extra_row_hit),
		.external_program_supply(external_program_supply), .eeprom_req(eeprom_req),
		.eeprom_req_valid(eeprom_req_valid), .eeprom_read_en(eeprom_read_en),
		.eeprom_select(eeprom_select),
		.eeprom_pump_on(eeprom_pump_on), .write_refused(write_refused));
	nvm_array_model far (.mclk(mclk), .eeprom_req(eeprom_req), .eeprom_pump_on(eeprom_pump_on),
		.peek_addr(peek_addr), .peek_data(peek_data));
	// 100 MHz is far above 1MHz, so the internal oscillator select stays clear
	initial begin
		forever #5 mclk = ~mclk;
	end
	// ==========================================
	// Bus tasks
	task automatic chk(input logic [39:0] seen, input logic [39:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic give_verdict;
		if (errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge mclk);
		bus_addr = a;
		bus_wdata = d;
		bus_we = 1'b1;
		@(negedge mclk);
		bus_we = 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a);
		int n = 0;
		@(negedge mclk);
		bus_addr = a;
		bus_re = 1'b1;
		@(negedge mclk);
		bus_re = 1'b0;
		while (bus_rvalid !== 1'b1 && n < 4) begin
			n++;
			@(negedge mclk);
		end
		if (n == 4) begin
			errors++;
			give_verdict();
		end else begin
			rd_q = bus_rdata;
		end
	endtask : rd
	// ==========================================
	// Sequence
	initial begin
		repeat (4) @(negedge mclk);
		srst = 1'b0;
		rd(ep);
		chk(rd_q, 8'h00, "eprom ctl reset");
		rd(ee);
		chk(rd_q, 8'h00, "eeprom ctl reset");
		rd(16'h0030);
		chk(rd_q, 8'h00, "unmapped read");
		bus_addr = 16'h0E00;
		#1;
		chk({eeprom_select, eeprom_read_en}, 2'b11, "rom read");
		// Voltage bit is refused here because the latch was still clear
		wr(ep, 8'hFF);
		rd(ep);
		chk(rd_q, 8'h20, "eprom ctl normal");
		wr(ep, 8'hFF);
		chk(external_program_supply, 1'b1, "supply on");
		wr(ep, 8'h00);
		chk(external_program_supply, 1'b0, "supply off");
		special_mode = 1'b1;
		wr(ep, 8'hFF);
		rd(ep);
		chk(rd_q, 8'hB8, "eprom ctl special");
		bus_addr = 16'h401F;
		#1;
		chk({user_array_disable, extra_column_hit, extra_row_hit}, 3'b111, "extra hit");
		bus_addr = 16'h4F80;
		#1;
		chk({user_array_disable, extra_column_hit, extra_row_hit}, 3'b100, "extra miss");
		wr(ep, 8'h00);
		for (int m = 0; m < 2; m++) begin
			wr(ep, m ? 8'hA0 : 8'h20);
			wr(16'h4026, 8'h5A);
			chk({eprom_req_valid, eprom_read_en}, 2'b10, "eprom capture");
			chk({eprom_req.ignore_mask, eprom_req.data}, {m ? 16'hC090 : 16'h0000, 8'h5A},
				"eprom req");
			wr(ep, m ? 8'hA1 : 8'h21);
			chk(external_program_supply, 1'b1, "supply prog");
			wr(ep, 8'h00);
			// The capture flag drops one cycle after the latch bit
			@(negedge mclk);
			chk({external_program_supply, eprom_req_valid}, 2'b00, "eprom idle");
		end
		// Scope bits set on purpose: programming must ignore them
		wr(ee, 8'hFA);
		rd(ee);
		chk(rd_q, 8'hDA, "eeprom ctl");
		wr(16'h0E25, 8'h3C);
		chk({eeprom_req_valid, eeprom_req}, {1'b1, 9'h025, 8'h3C, nvm_pkg::SCOPE_PROGRAM, 1'b1},
			"prog req");
		chk({eeprom_select, eeprom_read_en}, 2'b10, "latched rom");
		wr(16'h0E26, 8'h00);
		chk({write_refused, eeprom_req.addr}, {1'b1, 9'h025}, "other location");
		wr(ee, 8'hDB);
		chk(eeprom_pump_on, 1'b1, "pump on");
		wr(16'h0E25, 8'h00);
		chk(write_refused, 1'b1, "pumped write");
		wr(ee, 8'h00);
		chk(peek_data, 8'h3C, "cell programmed");
		foreach (ctl[i]) begin
			wr(ee, ctl[i]);
			wr(16'h0E25, 8'h00);
			chk({eeprom_req.scope, eeprom_req.data}, {scp[i], 8'hFF}, "erase req");
			wr(ee, ctl[i] | 8'h01);
			chk(eeprom_pump_on, 1'b1, "erase pump");
			wr(ee, 8'h00);
			chk(peek_data, 8'hFF, "cell erased");
			// Put data back so that the next erase has something to clear
			wr(ee, 8'h02);
			wr(16'h0E25, 8'h3C);
			wr(ee, 8'h03);
			wr(ee, 8'h00);
			chk(peek_data, 8'h3C, "cell reprogrammed");
		end
		wr(ee, 8'h01);
		rd(ee);
		chk(rd_q, 8'h00, "volt without latch");
		block_protect_register = 8'h01;
		eeprom_map_register = 4'h3;
		wr(ee, 8'h02);
		wr(16'h3E10, 8'h11);
		chk({write_refused, eeprom_req_valid}, 2'b10, "protected block");
		wr(16'h3E20, 8'h11);
		chk({eeprom_req_valid, eeprom_select}, 2'b11, "moved page");
		bus_addr = 16'h0E20;
		#1;
		chk(eeprom_select, 1'b0, "old page");
		wr(ee, 8'h00);
		give_verdict();
	end
endmodule : eprom_eeprom_program_control_tb_top
bind eprom_eeprom_program_control nvm_ctrl_chk chk (.mclk(mclk), .srst(srst),
	.special_mode(special_mode), .bus_addr(bus_addr), .bus_we(bus_we), .bus_rvalid(bus_rvalid),
	.bus_rdata(bus_rdata), .eprom_read_en(eprom_read_en), .eprom_req_valid(eprom_req_valid),
	.external_program_supply(external_program_supply), .eeprom_req_valid(eeprom_req_valid),
	.eeprom_read_en(eeprom_read_en), .eeprom_select(eeprom_select),
	.eeprom_pump_on(eeprom_pump_on), .write_refused(write_refused));
